// ---- src/irq_ctl_pkg.sv ----
// Purpose: Shared constants for the core interrupt control and context save block
// Assumes: 32-bit Avalon-MM register window, one word per register
// Notes: Register bytes sit in the low eight bits of each word
package irq_ctl_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_INTERRUPT_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_PERIPH_ENABLE_FIRST = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_PERIPH_ENABLE_SECOND = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_PIN_CHANGE_FLAGS = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_SHADOW_BASE = 8'h40;
  localparam int SHADOW_COUNT = 7;
  localparam int SH_WREG = 0;
  localparam int SH_STATUS = 1;
  localparam int SH_BANK = 2;
  localparam int SH_PTR_LOW = 3;
  localparam int SH_SPARE = 4;
  localparam int SH_PTR_HIGH = 5;
  localparam int SH_HIGH_LATCH = 6;
  localparam int BIT_GLOBAL_EN = 7;
  localparam int BIT_PERIPH_GATE = 6;
  localparam int BIT_TMR0_EN = 5;
  localparam int BIT_EXT_EN = 4;
  localparam int BIT_PCHG_EN = 3;
  localparam int BIT_TMR0_FLAG = 2;
  localparam int BIT_EXT_FLAG = 1;
  localparam int BIT_PCHG_FLAG = 0;
  localparam int BIT_SECOND_UNUSED = 1;
  localparam logic [7:0] SECOND_IMPL_MASK = 8'hFD;
  localparam logic [7:0] STATUS_KEEP_MASK = 8'hE7;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] PIE_RESET = 8'h00;
  localparam logic [14:0] IRQ_VECTOR = 15'h0004;
  localparam int ENTRY_CYCLES = 3;
  typedef enum logic [1:0] {ST_RUN, ST_WAIT, ST_VECTOR, ST_SERVICE} irq_state_t;
endpackage

// ---- src/pin_sync.sv ----
// Purpose: Three-stage synchroniser with agreement-based change detection
// Assumes: Input is asynchronous to mclk
// Notes: Output moves only once stages two and three agree
module pin_sync
  import irq_ctl_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic pin_in,
  output logic level_out
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Filtered level follows only an agreed value
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      level_out <= 1'b0;
    else if (clk_en && (s2_reg == s3_reg))
      level_out <= s3_reg;
  end
endmodule

// ---- src/shadow_bank.sv ----
// Purpose: Context shadow storage, saved on entry and read back on exit
// Assumes: Save and software write can land in one cycle; the caller does not keep them apart
// Notes: Save has priority over a software write
module shadow_bank
  import irq_ctl_pkg::*;
#(
  parameter int COUNT = SHADOW_COUNT
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic save,
  input wire logic [8*COUNT-1:0] live_in,
  input wire logic wr_en,
  input wire logic [2:0] wr_idx,
  input wire logic [7:0] wr_data,
  output logic [8*COUNT-1:0] shadow_out
);
  logic [7:0] mem_reg [COUNT];

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < COUNT; i++)
        mem_reg[i] <= 8'h00;
    end
    else if (clk_en)
    begin
      if (save)
      begin
        for (int i = 0; i < COUNT; i++)
          mem_reg[i] <= live_in[8*i +: 8];
      end
      else if (wr_en && (int'(wr_idx) < COUNT))
        mem_reg[wr_idx] <= wr_data;
    end
  end

  always_comb
  begin
    for (int i = 0; i < COUNT; i++)
      shadow_out[8*i +: 8] = mem_reg[i];
  end
endmodule

// ---- src/irq_ctl.sv ----
// Purpose: Core interrupt control, enable gating and automatic context save
// Assumes: Core sequencer hands over live context and accepts vector/restore pulses
// Notes: Shadow copies appear on the bus as the bank-31 window
// Function
// - Push return PC before vectoring
// - Save core context to shadows, status masked
// - Restore every saved register on exit
// - Shadows readable and writable by software
// - Global enable passes or blocks all
// - Peripheral gate passes peripheral requests
// - Timer overflow sets flag, bit 5 enables
// - External pin event sets flag, bit 4
// - Pin-change summary set if any flag
// - Summary read-only, clears with flag register
// - Flags set regardless of enables
// - First enable register gates eight sources
// - Second enable register gates seven sources
// - Second register bit 1 reads zero
// - All enables reset to zero
// - Entry flushes, clears global, loads vector
// - Return pops, restores, sets global
// - Edge select picks rising or falling
// - Entry latency three instruction cycles here
module irq_ctl
  import irq_ctl_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [irq_ctl_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [irq_ctl_pkg::DATA_W-1:0] avs_writedata,
  output logic [irq_ctl_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic ext_irq_pin,
  input wire logic external_edge_select,
  input wire logic timer_zero_overflow,
  input wire logic [7:0] pin_change_event,
  input wire logic [7:0] periph_flags_first,
  input wire logic [7:0] periph_flags_second,
  input wire logic instr_boundary,
  input wire logic return_from_irq_instruction,
  input wire logic [14:0] return_pc,
  input wire logic [7:0] live_wreg,
  input wire logic [7:0] live_status,
  input wire logic [7:0] live_bank_select,
  input wire logic [15:0] live_indirect_pointer,
  input wire logic [7:0] live_program_counter_high_latch,
  output logic irq_pending,
  output logic flush_prefetch,
  output logic push_return_pc,
  output logic [14:0] push_pc_value,
  output logic load_vector,
  output logic [14:0] vector_pc,
  output logic pop_return_pc,
  output logic restore_context,
  output logic [8*irq_ctl_pkg::SHADOW_COUNT-1:0] restore_data,
  output logic in_service
);
  logic [7:0] ctrl_reg;
  logic [7:0] en_first_reg;
  logic [7:0] en_second_reg;
  logic [7:0] pin_change_flag_register;
  logic ext_level;
  logic ext_level_d_reg;
  logic ext_edge;
  logic [8*SHADOW_COUNT-1:0] shadow_q;
  logic [8*SHADOW_COUNT-1:0] live_pack;
  logic shadow_wr;
  logic [2:0] shadow_idx;
  logic in_shadow_win;
  logic bus_wr;
  logic bus_rd;
  logic core_req;
  logic periph_req;
  logic irq_req;
  logic take_irq;
  logic [1:0] entry_cnt_reg;
  irq_state_t state_reg;
  logic [7:0] ctrl_read;
  logic [7:0] rd_byte;

  wire global_irq_enable = ctrl_reg[BIT_GLOBAL_EN];
  wire peripheral_irq_gate = ctrl_reg[BIT_PERIPH_GATE];
  wire timer_zero_overflow_enable = ctrl_reg[BIT_TMR0_EN];
  wire external_pin_irq_enable = ctrl_reg[BIT_EXT_EN];
  wire pin_change_irq_enable = ctrl_reg[BIT_PCHG_EN];
  wire timer_zero_overflow_flag = ctrl_reg[BIT_TMR0_FLAG];
  wire external_pin_irq_flag = ctrl_reg[BIT_EXT_FLAG];
  wire pin_change_summary_flag = |pin_change_flag_register;

  // Writes act only at edges where waitrequest is seen low, so a held request is
  // applied again every second edge; only a bit that hardware sets at that same edge (a flag, or global enable on return) survives a written zero
  assign bus_wr = clk_en && avs_write && avs_byteenable[0] && !avs_waitrequest;
  assign bus_rd = clk_en && avs_read;
  assign in_shadow_win = (avs_address >= OFF_SHADOW_BASE) &&
                         (avs_address < OFF_SHADOW_BASE + ADDR_W'(4 * SHADOW_COUNT));
  assign shadow_idx = 3'((avs_address - OFF_SHADOW_BASE) >> 2);
  assign shadow_wr = bus_wr && in_shadow_win;

  pin_sync ext_sync
  (
    .mclk(mclk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .pin_in(ext_irq_pin),
    .level_out(ext_level)
  );

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      ext_level_d_reg <= 1'b0;
    else if (clk_en)
      ext_level_d_reg <= ext_level;
  end

  assign ext_edge = external_edge_select ? (ext_level & ~ext_level_d_reg)
                                         : (~ext_level & ext_level_d_reg);

  // Status copy leaves out timeout and power-down bits
  assign live_pack = {live_program_counter_high_latch, live_indirect_pointer[15:8], 8'h00,
                      live_indirect_pointer[7:0], live_bank_select,
                      live_status & STATUS_KEEP_MASK, live_wreg};

  shadow_bank #(.COUNT(SHADOW_COUNT)) shadows
  (
    .mclk(mclk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .save(push_return_pc),
    .live_in(live_pack),
    .wr_en(shadow_wr),
    .wr_idx(shadow_idx),
    .wr_data(avs_writedata[7:0]),
    .shadow_out(shadow_q)
  );

  assign core_req = (timer_zero_overflow_enable & timer_zero_overflow_flag) |
                    (external_pin_irq_enable & external_pin_irq_flag) |
                    (pin_change_irq_enable & pin_change_summary_flag);
  assign periph_req = peripheral_irq_gate &
                      (|(en_first_reg & periph_flags_first) |
                       |(en_second_reg & SECOND_IMPL_MASK & periph_flags_second));
  assign irq_req = global_irq_enable & (core_req | periph_req);
  assign take_irq = irq_req && (state_reg == ST_RUN) && instr_boundary;

  // Control register: hardware sets beat software clears
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_reg <= CTRL_RESET;
    else if (clk_en)
    begin
      logic [7:0] ctrl_next;
      ctrl_next = ctrl_reg;
      if (bus_wr && avs_address == OFF_INTERRUPT_CONTROL)
        ctrl_next[7:1] = avs_writedata[7:1];
      if (take_irq)
        ctrl_next[BIT_GLOBAL_EN] = 1'b0;
      if (state_reg == ST_SERVICE && return_from_irq_instruction)
        ctrl_next[BIT_GLOBAL_EN] = 1'b1;
      if (timer_zero_overflow)
        ctrl_next[BIT_TMR0_FLAG] = 1'b1;
      if (ext_edge)
        ctrl_next[BIT_EXT_FLAG] = 1'b1;
      // Bit 0 is not stored; reads show the pin-change summary instead
      ctrl_next[BIT_PCHG_FLAG] = 1'b0;
      ctrl_reg <= ctrl_next;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      en_first_reg <= PIE_RESET;
      en_second_reg <= PIE_RESET;
    end
    else if (bus_wr)
    begin
      if (avs_address == OFF_PERIPH_ENABLE_FIRST)
        en_first_reg <= avs_writedata[7:0];
      if (avs_address == OFF_PERIPH_ENABLE_SECOND)
        en_second_reg <= avs_writedata[7:0] & SECOND_IMPL_MASK;
    end
  end

  // Pin-change flags: write one to a bit clears it, new event wins
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      pin_change_flag_register <= 8'h00;
    else if (clk_en)
    begin
      if (bus_wr && avs_address == OFF_PIN_CHANGE_FLAGS)
        pin_change_flag_register <= (pin_change_flag_register & ~avs_writedata[7:0]) |
                                    pin_change_event;
      else
        pin_change_flag_register <= pin_change_flag_register | pin_change_event;
    end
  end

  // Entry sequencer: boundary, wait, vector, then service
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_RUN;
      entry_cnt_reg <= 2'h0;
    end
    else if (clk_en)
    begin
      case (state_reg)
        ST_RUN:
          if (take_irq)
          begin
            state_reg <= ST_WAIT;
            entry_cnt_reg <= 2'h0;
          end
        ST_WAIT:
          if (entry_cnt_reg == 2'(ENTRY_CYCLES - 2))
            state_reg <= ST_VECTOR;
          else
            entry_cnt_reg <= entry_cnt_reg + 2'h1;
        ST_VECTOR:
          state_reg <= ST_SERVICE;
        ST_SERVICE:
          if (return_from_irq_instruction)
            state_reg <= ST_RUN;
        default:
          state_reg <= ST_RUN;
      endcase
    end
  end

  // Entry pulses leave together with the address that the core must push
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flush_prefetch <= 1'b0;
      push_return_pc <= 1'b0;
      push_pc_value <= 15'h0000;
    end
    else if (clk_en)
    begin
      flush_prefetch <= take_irq;
      push_return_pc <= take_irq;
      if (take_irq)
        push_pc_value <= return_pc;
    end
  end

  // Vector load marks the end of the fixed entry latency
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      load_vector <= 1'b0;
      vector_pc <= 15'h0000;
    end
    else if (clk_en)
    begin
      load_vector <= (state_reg == ST_WAIT) && (entry_cnt_reg == 2'(ENTRY_CYCLES - 2));
      vector_pc <= IRQ_VECTOR;
    end
  end

  // Return is honoured only while a service routine runs
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pop_return_pc <= 1'b0;
      restore_context <= 1'b0;
    end
    else if (clk_en)
    begin
      pop_return_pc <= (state_reg == ST_SERVICE) && return_from_irq_instruction;
      restore_context <= (state_reg == ST_SERVICE) && return_from_irq_instruction;
    end
  end

  // Status levels; in_service trails the state by one cycle
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      in_service <= 1'b0;
      irq_pending <= 1'b0;
    end
    else if (clk_en)
    begin
      in_service <= (state_reg != ST_RUN);
      irq_pending <= irq_req;
    end
  end

  // Shadows stay stable until the restore pulse, so a late software edit is honoured
  assign restore_data = shadow_q;

  always_comb
  begin
    ctrl_read = ctrl_reg;
    ctrl_read[BIT_PCHG_FLAG] = pin_change_summary_flag;
    rd_byte = 8'h00;
    if (in_shadow_win)
      rd_byte = shadow_q[8*shadow_idx +: 8];
    else
    begin
      case (avs_address)
        OFF_INTERRUPT_CONTROL: rd_byte = ctrl_read;
        OFF_PERIPH_ENABLE_FIRST: rd_byte = en_first_reg;
        OFF_PERIPH_ENABLE_SECOND: rd_byte = en_second_reg;
        OFF_PIN_CHANGE_FLAGS: rd_byte = pin_change_flag_register;
        OFF_STATUS: rd_byte = {5'h00, in_service, irq_req, irq_pending};
        default: rd_byte = 8'h00;
      endcase
    end
  end

  // Waitrequest drops for one cycle per request and freezes with the clock enable
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      avs_waitrequest <= 1'b1;
    else if (clk_en)
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
  end

  // Read data load while waitrequest is high and stand at the answering edge
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      avs_readdata <= 32'h0000_0000;
    else if (bus_rd)
      avs_readdata <= {24'h000000, rd_byte};
  end
endmodule

// ---- sim/irq_ctl_sva.sv ----
// Purpose: Port checks on irq_ctl bus answers and entry/exit sequencing
// Assumes: One clock domain, reset async low
// Notes: Bound from the bench top file
module irq_ctl_sva
  import irq_ctl_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [irq_ctl_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [irq_ctl_pkg::DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic return_from_irq_instruction,
  input wire logic [14:0] return_pc,
  input wire logic irq_pending,
  input wire logic flush_prefetch,
  input wire logic push_return_pc,
  input wire logic [14:0] push_pc_value,
  input wire logic load_vector,
  input wire logic [14:0] vector_pc,
  input wire logic pop_return_pc,
  input wire logic restore_context,
  input wire logic in_service
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  a_bus_answer: assert property ((avs_read || avs_write) |-> ##[0:2] !avs_waitrequest)
    else $error("bus request unanswered");
  a_second_bit_one: assert property (avs_read && !avs_waitrequest && avs_address == OFF_PERIPH_ENABLE_SECOND
    |-> !avs_readdata[BIT_SECOND_UNUSED]) else $error("unused enable bit reads one");
  a_entry_flush: assert property (push_return_pc |-> flush_prefetch ##1 in_service)
    else $error("push without flush");
  a_entry_vector: assert property (push_return_pc |-> ##2 load_vector && vector_pc == IRQ_VECTOR)
    else $error("vector load late or wrong");
  a_push_value: assert property (push_return_pc |-> push_pc_value == $past(return_pc))
    else $error("pushed pc wrong");
  a_pending_cause: assert property (push_return_pc |-> irq_pending)
    else $error("entry without pending");
  a_global_clear: assert property (push_return_pc |-> ##2 !irq_pending)
    else $error("global enable not cleared");
  a_exit_restore: assert property ($rose(return_from_irq_instruction) && in_service
    |-> ##[1:2] pop_return_pc && restore_context) else $error("return not served");
  c_entry: cover property (push_return_pc);
  c_exit: cover property (restore_context);
  c_read: cover property (avs_read && !avs_waitrequest);
endmodule

// ---- sim/core_seq_model.sv ----
// Purpose: Core sequencer stand-in: program counter, live context, return
// Assumes: The service routine is reduced to one scribble of live context
// Notes: SLOW offers a boundary only every other cycle
module core_seq_model #(
  parameter bit SLOW = 1'h1
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ret_go,
  input wire logic [55:0] ctx_init,
  input wire logic load_vector,
  input wire logic restore_context,
  input wire logic in_service,
  input wire logic [55:0] restore_data,
  output logic instr_boundary,
  output logic return_from_irq_instruction,
  output logic [14:0] return_pc,
  output logic [55:0] ctx
);
  logic sent;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      instr_boundary <= 1'h0;
      return_from_irq_instruction <= 1'h0;
      return_pc <= 15'h0100;
      ctx <= ctx_init;
      sent <= 1'h0;
    end
    else
    begin
      instr_boundary <= SLOW ? ~instr_boundary : 1'h1;
      if (!in_service)
        return_pc <= return_pc + 15'h0001;
      return_from_irq_instruction <= ret_go && in_service && !sent;
      sent <= ret_go;
      // Scribble so that a missing restore cannot pass unseen
      if (load_vector)
        ctx <= ~ctx;
      else if (restore_context)
        ctx <= restore_data;
    end
  end
endmodule

// ---- sim/tb_core_interrupt_control_and_context_save.sv ----
// Purpose: Self-checking bench for irq_ctl with a core sequencer model
// Assumes: clk_en held high, all byte lanes enabled
// Notes: Expected results are queued; a watcher pops one per read or restore
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_core_interrupt_control_and_context_save;
  timeunit 1ns;
  timeprecision 1ns;
  import irq_ctl_pkg::*;
  logic mclk = 1'h0, rst_n = 1'h0, clk_en = 1'h1, avs_read = 1'h0, avs_write = 1'h0;
  logic [ADDR_W-1:0] avs_address = 8'h00;
  logic [3:0] avs_byteenable = 4'hF;
  logic [DATA_W-1:0] avs_writedata = 32'h0, avs_readdata;
  logic avs_waitrequest, ext_irq_pin = 1'h0, external_edge_select = 1'h0, timer_zero_overflow = 1'h0;
  logic [7:0] pin_change_event = 8'h00, periph_flags_first = 8'h00, periph_flags_second = 8'h00, v;
  logic ret_go = 1'h0, instr_boundary, return_from_irq_instruction, irq_pending, flush_prefetch;
  logic push_return_pc, load_vector, pop_return_pc, restore_context, in_service;
  logic [14:0] return_pc, push_pc_value, vector_pc;
  logic [55:0] ctx, ctx_init, restore_data, exp_sh;
  logic [63:0] exp_q[$], e;
  int errors = 0, n_checks = 0, seed = 50118, b;
  wire logic [7:0] live_wreg = ctx[7:0];
  wire logic [7:0] live_status = ctx[15:8];
  wire logic [7:0] live_bank_select = ctx[23:16];
  wire logic [15:0] live_indirect_pointer = {ctx[47:40], ctx[31:24]};
  wire logic [7:0] live_program_counter_high_latch = ctx[55:48];
  irq_ctl DUT (.*);
  core_seq_model #(.SLOW(1'h1)) m (.*);
  always #50 mclk = ~mclk;
  task automatic complete_run();
    if (errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    for (i = 0; i < 20; i++)
    begin
      @(posedge mclk);
      if (!avs_waitrequest)
        break;
    end
    if (i == 20)
    begin
      errors++;
      complete_run();
    end
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    exp_q.push_back({32'h0, x});
    bus(1'h0, a, 32'h0);
  endtask
  always @(posedge mclk)
  begin
    if (avs_read && !avs_waitrequest)
    begin
      e = exp_q.pop_front();
      `CHK("readdata", e[31:0], avs_readdata)
    end
    if (restore_context)
    begin
      e = exp_q.pop_front();
      `CHK("restore_data", e[55:0], restore_data)
    end
  end
  initial
  begin
    ctx_init = 56'({$random(seed), $random(seed)});
    exp_sh = {ctx_init[55:40], 8'h00, ctx_init[31:16], ctx_init[15:8] & STATUS_KEEP_MASK, ctx_init[7:0]};
    tick(2);
    rst_n <= 1'h1;
    tick(1);
    rd(OFF_INTERRUPT_CONTROL, 32'h0);
    rd(OFF_PERIPH_ENABLE_SECOND, 32'h0);
    rd(8'h20, 32'h0);
    bus(1'h1, OFF_PERIPH_ENABLE_SECOND, 32'hFF);
    rd(OFF_PERIPH_ENABLE_SECOND, 32'hFD);
    b = $unsigned($random(seed)) % 8;
    bus(1'h1, OFF_PERIPH_ENABLE_FIRST, 32'h1 << b);
    rd(OFF_PERIPH_ENABLE_FIRST, 32'h1 << b);
    bus(1'h1, OFF_INTERRUPT_CONTROL, 32'h7F);
    rd(OFF_INTERRUPT_CONTROL, 32'h7E);
    bus(1'h1, OFF_INTERRUPT_CONTROL, 32'h00);
    timer_zero_overflow <= 1'h1;
    pin_change_event <= 8'h10;
    ext_irq_pin <= 1'h1;
    tick(1);
    timer_zero_overflow <= 1'h0;
    pin_change_event <= 8'h00;
    tick(6);
    rd(OFF_INTERRUPT_CONTROL, 32'h05);
    ext_irq_pin <= 1'h0;
    tick(6);
    rd(OFF_INTERRUPT_CONTROL, 32'h07);
    bus(1'h1, OFF_PIN_CHANGE_FLAGS, 32'hFF);
    rd(OFF_INTERRUPT_CONTROL, 32'h06);
    external_edge_select <= 1'h1;
    bus(1'h1, OFF_INTERRUPT_CONTROL, 32'h00);
    ext_irq_pin <= 1'h1;
    tick(6);
    rd(OFF_INTERRUPT_CONTROL, 32'h02);
    periph_flags_first <= 8'h1 << b;
    bus(1'h1, OFF_INTERRUPT_CONTROL, 32'h40);
    rd(OFF_STATUS, 32'h0);
    bus(1'h1, OFF_INTERRUPT_CONTROL, 32'h80);
    rd(OFF_STATUS, 32'h0);
    bus(1'h1, OFF_INTERRUPT_CONTROL, 32'hC0);
    tick(8);
    periph_flags_first <= 8'h00;
    rd(OFF_INTERRUPT_CONTROL, 32'h40);
    for (int i = 0; i < SHADOW_COUNT; i++)
      rd(OFF_SHADOW_BASE + 8'(4 * i), {24'h0, exp_sh[8*i +: 8]});
    v = 8'($random(seed));
    bus(1'h1, OFF_SHADOW_BASE, {24'h0, v});
    exp_sh[7:0] = v;
    exp_q.push_back({8'h00, exp_sh});
    ret_go <= 1'h1;
    tick(6);
    ret_go <= 1'h0;
    rd(OFF_INTERRUPT_CONTROL, 32'hC0);
    rst_n <= 1'h0;
    tick(2);
    rst_n <= 1'h1;
    tick(1);
    rd(OFF_PERIPH_ENABLE_FIRST, 32'h0);
    `CHK("queue_left", 32'h0, 32'(exp_q.size()))
    complete_run();
  end
  initial
  begin
    tick(5000);
    errors++;
    complete_run();
  end
endmodule
bind irq_ctl irq_ctl_sva chk (.*);
